// ===== design/dsclk_pkg.sv
package dsclk_pkg;

  // core phase generator needs this many of its own clock periods per machine cycle
  localparam logic [2:0] DSCLK_PHASES_PER_CYCLE = 3'h6;
  localparam logic [2:0] DSCLK_PHASE_LAST       = 3'h5;
  localparam logic [2:0] DSCLK_PHASE_RESET      = 3'h0;

  // halving stage ratio, for reference by the bench
  localparam int unsigned DSCLK_DIV_RATIO = 2;

  // reset values
  localparam logic DSCLK_HALF_RESET  = 1'b0;
  localparam logic DSCLK_MODE_RESET  = 1'b0;
  localparam logic DSCLK_XTAL_RESET  = 1'b0;

  typedef enum logic [1:0] {
    DSCLK_RUN   = 2'b00,
    DSCLK_IDLE  = 2'b01,
    DSCLK_PDOWN = 2'b10
  } dsclk_pwr_t;

endpackage : dsclk_pkg

// ===== design/dsclk_core_if.sv
`timescale 1ns/1ps
interface dsclk_core_if;
  logic       tick;
  logic [2:0] phase;
  logic       cycleEnd;

  modport gen (output tick, input phase, input cycleEnd);
  modport seq (input tick, output phase, output cycleEnd);
endinterface : dsclk_core_if

// ===== design/dsclk_phase_gen.sv
`timescale 1ns/1ps
module dsclk_phase_gen
  import dsclk_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // core tick in, phase out
  dsclk_core_if.seq core
);

  logic [2:0] phaseCount;
  logic       cycleEndPulse;

  // six ticks of the core clock make one machine cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phaseCount <= DSCLK_PHASE_RESET;
    end else if (core.tick) begin
      if (phaseCount == DSCLK_PHASE_LAST) begin
        phaseCount <= DSCLK_PHASE_RESET;
      end else begin
        phaseCount <= phaseCount + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cycleEndPulse <= 1'b0;
    end else begin
      cycleEndPulse <= core.tick && (phaseCount == DSCLK_PHASE_LAST);
    end
  end

  assign core.phase    = phaseCount;
  assign core.cycleEnd = cycleEndPulse;

endmodule : dsclk_phase_gen

// ===== design/dsclk_clock_gen.sv
`timescale 1ns/1ps
// Operation
// - crystal halved before phase generator; software bypassable
// - double speed: six crystal periods per cycle
// - double speed feeds core, peripherals from crystal
// - select bit applied only on halved rising edge
// - speed may change while running or idle
// - idle stops cpu clock, peripherals keep running
// - power-down stops all clocks, RAM retained
module dsclk_clock_gen
  import dsclk_pkg::*;
(
  // system clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // crystal side
  input  wire logic       crystalInput,
  // software control
  input  wire logic       doubleSpeedSelect,
  input  wire logic       idleRequest,
  input  wire logic       powerDownRequest,
  // wake sources
  input  wire logic       enabledIrq,
  input  wire logic       enabledExtIrq,
  // clock ticks to core and peripherals
  output logic            cpuTick,
  output logic            periphTick,
  output logic            machineCycle,
  output logic [2:0]      corePhase,
  // status
  output logic            halfClock,
  output logic            doubleSpeedActive,
  output logic            idleActive,
  output logic            powerDownActive,
  output logic            ramRetain
);

  dsclk_core_if core ();

  dsclk_pwr_t pwrState;
  dsclk_pwr_t next_pwrState;
  logic       xtalPrev;
  logic       xtalEdge;
  logic       oscRunning;
  logic       xtalRise;
  logic       halfRise;
  logic       srcTick;
  logic       wakeNow;
  logic       next_idleActive;
  logic       next_powerDownActive;

  // power state decodes, shared by tick gating and the status flags
  function automatic logic dsclk_is_run(input dsclk_pwr_t s);
    return (s == DSCLK_RUN);
  endfunction : dsclk_is_run

  function automatic logic dsclk_is_idle(input dsclk_pwr_t s);
    return (s == DSCLK_IDLE);
  endfunction : dsclk_is_idle

  function automatic logic dsclk_is_pdown(input dsclk_pwr_t s);
    return (s == DSCLK_PDOWN);
  endfunction : dsclk_is_pdown

  // wake source per low-power state; reset wakes both through the clear
  function automatic logic dsclk_wake(input dsclk_pwr_t s,
                                      input logic       irq,
                                      input logic       extIrq);
    logic wake;
    wake = 1'b0;
    if (s == DSCLK_IDLE) begin
      wake = irq;
    end else if (s == DSCLK_PDOWN) begin
      wake = extIrq;
    end
    return wake;
  endfunction : dsclk_wake

  // crystal is sampled as a synchronous level; edges come from one history flop
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      xtalPrev <= DSCLK_XTAL_RESET;
    end else begin
      xtalPrev <= crystalInput;
    end
  end

  assign xtalEdge = crystalInput && !xtalPrev;

  // oscillator is treated as stopped in power-down, so no edges pass;
  // an external source that keeps running is masked here just the same
  assign oscRunning = !dsclk_is_pdown(pwrState);
  assign xtalRise   = xtalEdge && oscRunning;

  // divide-by-two stage, any input duty cycle is fine here
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      halfClock <= DSCLK_HALF_RESET;
    end else if (xtalRise) begin
      halfClock <= !halfClock;
    end
  end

  assign halfRise = xtalRise && !halfClock;

  // mode only changes on the halved rising edge, so a switch never leaves
  // a short core period behind; keeps working in idle since the divider runs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      doubleSpeedActive <= DSCLK_MODE_RESET;
    end else if (halfRise) begin
      doubleSpeedActive <= doubleSpeedSelect;
    end
  end

  // bypass the divider in double speed: every crystal rising edge is a clock;
  // limitation: the crystal duty cycle then reaches the core, keep it near half
  assign srcTick = doubleSpeedActive ? xtalRise : halfRise;

  assign wakeNow = dsclk_wake(pwrState, enabledIrq, enabledExtIrq);

  // power state: power-down request wins over idle request
  always_comb begin
    next_pwrState = pwrState;
    case (pwrState)
      DSCLK_RUN: begin
        if (powerDownRequest) begin
          next_pwrState = DSCLK_PDOWN;
        end else if (idleRequest) begin
          next_pwrState = DSCLK_IDLE;
        end
      end
      DSCLK_IDLE: begin
        if (wakeNow) begin
          next_pwrState = DSCLK_RUN;
        end
      end
      DSCLK_PDOWN: begin
        if (wakeNow) begin
          next_pwrState = DSCLK_RUN;
        end
      end
      default: begin
        next_pwrState = DSCLK_RUN;
      end
    endcase
  end

  // reset also wakes both modes through the asynchronous clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwrState <= DSCLK_RUN;
    end else begin
      pwrState <= next_pwrState;
    end
  end

  // status flags come from flops loaded with the next state decode,
  // so they change on the same edge as the state register itself
  always_comb begin
    next_idleActive      = dsclk_is_idle(next_pwrState);
    next_powerDownActive = dsclk_is_pdown(next_pwrState);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idleActive <= 1'b0;
    end else begin
      idleActive <= next_idleActive;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      powerDownActive <= 1'b0;
    end else begin
      powerDownActive <= next_powerDownActive;
    end
  end

  // memory keeps its contents in power-down; nothing here clears it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ramRetain <= 1'b0;
    end else begin
      ramRetain <= next_powerDownActive;
    end
  end

  // ticks are combinational enables so the core sees them in the same cycle
  assign periphTick = srcTick && !dsclk_is_pdown(pwrState);
  assign cpuTick    = srcTick && dsclk_is_run(pwrState);

  assign core.tick = cpuTick;

  // six cpu ticks per cycle: six crystal periods in double speed, twelve else
  dsclk_phase_gen u_phase (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .core    (core.seq)
  );

  assign machineCycle    = core.cycleEnd;
  assign corePhase       = core.phase;

endmodule : dsclk_clock_gen

// ===== testbench/dsclk_asserts.sv
`timescale 1ns/1ps
module dsclk_asserts
  import dsclk_pkg::*;
(
  // watched ports
  input wire logic       clk_sys, resetn, crystalInput, doubleSpeedSelect, enabledExtIrq,
  input wire logic       cpuTick, periphTick, machineCycle, halfClock, doubleSpeedActive,
  input wire logic       idleActive, powerDownActive, ramRetain,
  input wire logic [2:0] corePhase
);
  logic prev;
  wire logic rise = crystalInput && !prev && !powerDownActive;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) prev <= 1'b0;
    else prev <= crystalInput;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  half_toggle_a: assert property (rise |=> halfClock != $past(halfClock)) else $error("half");
  std_tick_a: assert property (periphTick |-> rise && (doubleSpeedActive || !halfClock))
    else $error("tick off rise");
  x2_tick_a: assert property (rise && doubleSpeedActive |-> periphTick) else $error("x2");
  mode_hold_a: assert property ($changed(doubleSpeedActive) |-> $past(rise && !halfClock))
    else $error("mode moved");
  mode_take_a: assert property (rise && !halfClock |=> doubleSpeedActive == $past(doubleSpeedSelect))
    else $error("mode take");
  cpu_run_a: assert property (!idleActive |-> cpuTick == periphTick) else $error("cpu");
  idle_cpu_a: assert property (idleActive |-> !cpuTick) else $error("idle cpu");
  pdown_stop_a: assert property (powerDownActive |-> !periphTick && ramRetain) else $error("pd");
  pdown_wake_a: assert property (powerDownActive && enabledExtIrq |=> !powerDownActive)
    else $error("wake");
  cycle_end_a: assert property (cpuTick && corePhase == 3'h5 |=> machineCycle && corePhase == 3'h0)
    else $error("cycle");
endmodule : dsclk_asserts

// ===== testbench/dsclk_xtal_model.sv
`timescale 1ns/1ps
module dsclk_xtal_model (
  input  wire logic       clk_sys,
  input  wire logic       run,
  input  wire logic [3:0] halfPer,
  output logic            crystalInput
);
  int cnt = 0;
  initial crystalInput = 1'b0;
  // a stopped oscillator stands low rather than holding a stale level
  always @(negedge clk_sys) begin
    if (!run) begin
      crystalInput <= 1'b0;
      cnt = 0;
    end else if (++cnt >= halfPer) begin
      cnt = 0;
      crystalInput <= !crystalInput;
    end
  end
endmodule : dsclk_xtal_model

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb
  import dsclk_pkg::*;
;
  logic clk_sys = 0, resetn = 0, run = 1, doubleSpeedSelect = 0, idleRequest = 0;
  logic powerDownRequest = 0, enabledIrq = 0, enabledExtIrq = 0, crystalInput;
  logic cpuTick, periphTick, machineCycle, halfClock, doubleSpeedActive;
  logic idleActive, powerDownActive, ramRetain;
  logic [2:0] corePhase;
  int bad_count = 0, comparisons = 0, n, c, p;
  dsclk_clock_gen DUT (.*);
  dsclk_xtal_model xtal (.clk_sys, .run, .halfPer(4'h2), .crystalInput);
  initial forever #20 clk_sys = !clk_sys;
  task chk(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %0h want %0h", $time, seen, exp);
    end
  endtask : chk
  task span();
    n = 0;
    do @(negedge clk_sys); while (!machineCycle);
    do begin @(negedge clk_sys); n++; end while (!machineCycle && n < 200);
  endtask : span
  task t_speed(logic sel, int exp);
    doubleSpeedSelect = sel;
    span();
    span();
    chk(n, exp);
    chk(doubleSpeedActive, sel);
    $display("speed test done");
  endtask : t_speed
  task t_idle();
    idleRequest = 1;
    @(negedge clk_sys) idleRequest = 0;
    chk(idleActive, 1);
    doubleSpeedSelect = 0;
    c = 0;
    p = 0;
    repeat (40) begin @(negedge clk_sys); #1; c += cpuTick; p += periphTick; end
    chk(c, 0);
    chk(p != 0, 1);
    chk(doubleSpeedActive, 0);
    enabledIrq = 1;
    @(negedge clk_sys) enabledIrq = 0;
    chk(idleActive, 0);
    $display("idle test done");
  endtask : t_idle
  task t_pdown();
    powerDownRequest = 1;
    @(negedge clk_sys) powerDownRequest = 0;
    chk(powerDownActive && ramRetain, 1);
    p = 0;
    repeat (40) begin @(negedge clk_sys); #1; p += periphTick; end
    chk(p, 0);
    run = 0;
    enabledExtIrq = 1;
    @(negedge clk_sys) enabledExtIrq = 0;
    run = 1;
    chk(powerDownActive, 0);
    $display("power-down test done");
  endtask : t_pdown
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (12) @(negedge clk_sys);
    resetn = 1;
    t_speed(1'b0, DSCLK_PHASES_PER_CYCLE * DSCLK_DIV_RATIO * 4);
    t_speed(1'b1, DSCLK_PHASES_PER_CYCLE * 4);
    t_idle();
    t_pdown();
    t_speed(1'b0, DSCLK_PHASES_PER_CYCLE * DSCLK_DIV_RATIO * 4);
    report_and_stop();
  end
  // whole run is under a thousand cycles
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
endmodule : tb
bind dsclk_clock_gen dsclk_asserts u_chk (.*);
